// ===== design/mac_pkg.sv
package mac_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned WH_W = 48;
  localparam int unsigned WIDE_W = 64;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ADR_W = 8;
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_OPND_FIRST = 8'h00;
  localparam logic [ADR_W-1:0] OFF_OPND_SECOND = 8'h04;
  localparam logic [ADR_W-1:0] OFF_ACCUM = 8'h08;
  localparam logic [ADR_W-1:0] OFF_WIDE_UPPER = 8'h0c;
  localparam logic [ADR_W-1:0] OFF_WIDE_LOWER = 8'h10;
  localparam logic [ADR_W-1:0] OFF_CTRL = 8'h14;
  localparam logic [ADR_W-1:0] OFF_RESULT = 8'h18;
  localparam logic [ADR_W-1:0] OFF_STATUS = 8'h1c;
  // Control word fields
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_OP_W = 4;
  localparam int unsigned CTRL_SEL_FIRST_BIT = 4;
  localparam int unsigned CTRL_SEL_SECOND_BIT = 5;
  localparam int unsigned CTRL_SET_FLAGS_BIT = 6;
  localparam int unsigned CTRL_GO_BIT = 7;
  // Status word fields: flags in the low bits, busy above
  localparam int unsigned STAT_W = 5;
  localparam int unsigned STAT_BUSY_BIT = 5;
  // Reset and idle values
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
  // Operation codes
  typedef enum logic [CTRL_OP_W-1:0] {
    OP_PRODUCT_LOW = 4'b0000,
    OP_PRODUCT_PLUS_ADDEND = 4'b0001,
    OP_ADDEND_MINUS_PRODUCT = 4'b0010,
    OP_UNSIGNED_WIDE_PRODUCT = 4'b0011,
    OP_WIDE_DOUBLE_ACCUM = 4'b0100,
    OP_WIDE_ACCUM = 4'b0101,
    OP_HALF_BY_HALF_ACCUM = 4'b0110,
    OP_WORD_BY_HALF_ACCUM = 4'b0111,
    OP_DUAL_HALF_ACCUM = 4'b1000,
    OP_DUAL_HALF_CROSSED_ACCUM = 4'b1001
  } mac_op_t;
  // Condition flags, saturation flag lowest
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic q;
  } mac_flags_t;
  // Sign-extended top or bottom halfword
  function automatic logic signed [DATA_W-1:0] half_ext(input logic [DATA_W-1:0] w, input logic top);
    logic signed [HALF_W-1:0] h;
    h = top ? w[DATA_W-1:HALF_W] : w[HALF_W-1:0];
    half_ext = DATA_W'(h);
  endfunction : half_ext
  // Signed overflow of s = a + b
  function automatic logic add_overflow(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                        input logic [DATA_W-1:0] s);
    add_overflow = (a[DATA_W-1] == b[DATA_W-1]) && (s[DATA_W-1] != a[DATA_W-1]);
  endfunction : add_overflow
  // Byte-lane write merge
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w, input logic [SEL_W-1:0] sel);
    merge_bytes = old_w;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        merge_bytes[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
  endfunction : merge_bytes
endpackage : mac_pkg

// ===== design/mac_op_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one operation between the register file, datapath and flag logic
interface mac_op_if;
  import mac_pkg::*;
  mac_op_t op;
  logic sel_first_top;
  logic sel_second_top;
  logic set_flags;
  logic fire;
  logic [DATA_W-1:0] first;
  logic [DATA_W-1:0] second;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] wide_upper;
  logic [DATA_W-1:0] wide_lower;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] wide_upper_res;
  logic [DATA_W-1:0] wide_lower_res;
  logic acc_overflow;
  logic writes_single;
  logic writes_wide;
  mac_flags_t flags_now;
  mac_flags_t flags_next;
  modport datapath (input op, sel_first_top, sel_second_top, first, second, accum, wide_upper, wide_lower,
                    output result, wide_upper_res, wide_lower_res, acc_overflow, writes_single, writes_wide);
  modport status (input op, set_flags, fire, result, acc_overflow, flags_now, output flags_next);
endinterface : mac_op_if
`default_nettype wire

// ===== design/mac_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module mac_datapath (
  // Operation in, results out
  mac_op_if.datapath dp
);
  import mac_pkg::*;
  // One unsigned 64-bit product; its low word is also the signed low word
  logic [WIDE_W-1:0] wide_prod;
  logic signed [DATA_W-1:0] half_prod;
  logic signed [WH_W-1:0] wh_prod;
  logic signed [DATA_W-1:0] dual_top;
  logic signed [DATA_W-1:0] dual_bot;
  logic crossed;
  logic [DATA_W-1:0] half_sum;
  logic [DATA_W-1:0] wh_sum;
  assign wide_prod = WIDE_W'(dp.first) * WIDE_W'(dp.second);
  assign half_prod = half_ext(dp.first, dp.sel_first_top) * half_ext(dp.second, dp.sel_second_top);
  assign wh_prod = signed'(dp.first) * half_ext(dp.second, dp.sel_second_top);
  assign crossed = (dp.op == OP_DUAL_HALF_CROSSED_ACCUM);
  // Top half of the first operand meets top or bottom of the second
  assign dual_top = half_ext(dp.first, 1'b1) * half_ext(dp.second, !crossed);
  assign dual_bot = half_ext(dp.first, 1'b0) * half_ext(dp.second, crossed);
  assign half_sum = dp.accum + half_prod;
  assign wh_sum = dp.accum + wh_prod[WH_W-1:HALF_W];
  // Result select; undefined codes write nothing
  always_comb begin
    dp.result = ZERO_WORD;
    dp.wide_upper_res = dp.wide_upper;
    dp.wide_lower_res = dp.wide_lower;
    dp.acc_overflow = 1'b0;
    dp.writes_single = 1'b0;
    dp.writes_wide = 1'b0;
    unique case (dp.op)
      OP_PRODUCT_LOW: begin
        dp.result = wide_prod[DATA_W-1:0];
        dp.writes_single = 1'b1;
      end
      OP_PRODUCT_PLUS_ADDEND: begin
        dp.result = dp.accum + wide_prod[DATA_W-1:0];
        dp.writes_single = 1'b1;
      end
      OP_ADDEND_MINUS_PRODUCT: begin
        dp.result = dp.accum - wide_prod[DATA_W-1:0];
        dp.writes_single = 1'b1;
      end
      OP_UNSIGNED_WIDE_PRODUCT: begin
        {dp.wide_upper_res, dp.wide_lower_res} = wide_prod;
        dp.writes_wide = 1'b1;
      end
      OP_WIDE_DOUBLE_ACCUM: begin
        {dp.wide_upper_res, dp.wide_lower_res} = wide_prod + WIDE_W'(dp.wide_upper) + WIDE_W'(dp.wide_lower);
        dp.writes_wide = 1'b1;
      end
      OP_WIDE_ACCUM: begin
        {dp.wide_upper_res, dp.wide_lower_res} = wide_prod + {dp.wide_upper, dp.wide_lower};
        dp.writes_wide = 1'b1;
      end
      OP_HALF_BY_HALF_ACCUM: begin
        dp.result = half_sum;
        dp.acc_overflow = add_overflow(dp.accum, half_prod, half_sum);
        dp.writes_single = 1'b1;
      end
      OP_WORD_BY_HALF_ACCUM: begin
        dp.result = wh_sum;
        dp.acc_overflow = add_overflow(dp.accum, wh_prod[WH_W-1:HALF_W], wh_sum);
        dp.writes_single = 1'b1;
      end
      OP_DUAL_HALF_ACCUM, OP_DUAL_HALF_CROSSED_ACCUM: begin
        dp.result = dp.accum + dual_top + dual_bot;
        dp.writes_single = 1'b1;
      end
      default: begin
        dp.writes_single = 1'b0;
      end
    endcase
  end
endmodule : mac_datapath
`default_nettype wire

// ===== design/mac_flags.sv
`timescale 1ns/1ps
`default_nettype none
module mac_flags (
  // Outcome in, next flags out
  mac_op_if.status st
);
  import mac_pkg::*;
  // Hardware updates land on top of any software write, so a set wins
  always_comb begin
    st.flags_next = st.flags_now;
    // Only the flagged plain product touches N and Z; C and V never move
    if (st.fire && st.op == OP_PRODUCT_LOW && st.set_flags) begin
      st.flags_next.n = st.result[DATA_W-1];
      st.flags_next.z = (st.result == ZERO_WORD);
    end
    // Saturation only ever sets here
    if (st.fire && st.acc_overflow) begin
      st.flags_next.q = 1'b1;
    end
  end
endmodule : mac_flags
`default_nettype wire

// ===== design/mac_unit.sv
`timescale 1ns/1ps
`default_nettype none
module mac_unit #(
  parameter int unsigned WORD_W = mac_pkg::DATA_W
) (
  // Clock, reset and freeze
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mac_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [mac_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [mac_pkg::SEL_W-1:0] wb_sel_i,
  output logic [mac_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o
);
  import mac_pkg::*;

  // The datapath is written for one word width only
  if (WORD_W != DATA_W) begin : g_width_check
    $error("mac_unit supports only a 32-bit word");
  end

  // Bus state
  logic ack_q; // Answer flag, high one cycle
  logic [DATA_W-1:0] rdata_q; // Read data, loaded with the answer
  logic [DATA_W-1:0] read_word; // Read mux
  logic req; // Request present
  logic wr_take; // Write lands on this edge
  // Operand registers
  logic [DATA_W-1:0] opnd_first_q;
  logic [DATA_W-1:0] opnd_second_q;
  logic [DATA_W-1:0] accum_q;
  // Destinations
  logic [DATA_W-1:0] wide_upper_q;
  logic [DATA_W-1:0] wide_lower_q;
  logic [DATA_W-1:0] result_q;
  // Control
  mac_op_t op_q;
  logic sel_first_top_q;
  logic sel_second_top_q;
  logic set_flags_q;
  logic fire_q; // Execute pulse
  logic [DATA_W-1:0] ctrl_word;
  // Status
  mac_flags_t flags_q;
  logic [DATA_W-1:0] status_word;
  // Write strobes per register
  logic wr_first;
  logic wr_second;
  logic wr_accum;
  logic wr_upper;
  logic wr_lower;
  logic wr_ctrl;
  logic wr_stat;
  logic go;

  mac_op_if opif ();

  assign req = wb_cyc_i && wb_stb_i;
  // Writes take effect on the edge at which the master sees ack
  assign wr_take = req && wb_we_i && ack_q;
  assign wr_first = wr_take && (wb_adr_i == OFF_OPND_FIRST);
  assign wr_second = wr_take && (wb_adr_i == OFF_OPND_SECOND);
  assign wr_accum = wr_take && (wb_adr_i == OFF_ACCUM);
  assign wr_upper = wr_take && (wb_adr_i == OFF_WIDE_UPPER);
  assign wr_lower = wr_take && (wb_adr_i == OFF_WIDE_LOWER);
  // Control and status live in byte lane 0
  assign wr_ctrl = wr_take && (wb_adr_i == OFF_CTRL) && wb_sel_i[0];
  assign wr_stat = wr_take && (wb_adr_i == OFF_STATUS) && wb_sel_i[0];
  assign go = wr_ctrl && wb_dat_i[CTRL_GO_BIT];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Feed the shared operation carrier
  assign opif.op = op_q;
  assign opif.sel_first_top = sel_first_top_q;
  assign opif.sel_second_top = sel_second_top_q;
  assign opif.set_flags = set_flags_q;
  assign opif.fire = fire_q;
  assign opif.first = opnd_first_q;
  assign opif.second = opnd_second_q;
  assign opif.accum = accum_q;
  assign opif.wide_upper = wide_upper_q;
  assign opif.wide_lower = wide_lower_q;
  // Software write first, hardware updates applied on top of it
  assign opif.flags_now = wr_stat ? mac_flags_t'(wb_dat_i[STAT_W-1:0]) : flags_q;

  mac_datapath u_datapath (
    .dp (opif.datapath)
  );

  mac_flags u_flags (
    .st (opif.status)
  );

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data sampled as the ack rises; unmapped reads give zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= ZERO_WORD;
    end else if (clk_en && req && !ack_q) begin
      rdata_q <= read_word;
    end
  end

  // Control readback, go reads as zero
  always_comb begin
    ctrl_word = ZERO_WORD;
    ctrl_word[CTRL_OP_LSB +: CTRL_OP_W] = op_q;
    ctrl_word[CTRL_SEL_FIRST_BIT] = sel_first_top_q;
    ctrl_word[CTRL_SEL_SECOND_BIT] = sel_second_top_q;
    ctrl_word[CTRL_SET_FLAGS_BIT] = set_flags_q;
  end

  // Status readback: flags and busy
  always_comb begin
    status_word = ZERO_WORD;
    status_word[STAT_W-1:0] = flags_q;
    status_word[STAT_BUSY_BIT] = fire_q;
  end

  // Register read mux
  always_comb begin
    read_word = UNMAPPED_READ;
    unique case (wb_adr_i)
      OFF_OPND_FIRST: read_word = opnd_first_q;
      OFF_OPND_SECOND: read_word = opnd_second_q;
      OFF_ACCUM: read_word = accum_q;
      OFF_WIDE_UPPER: read_word = wide_upper_q;
      OFF_WIDE_LOWER: read_word = wide_lower_q;
      OFF_CTRL: read_word = ctrl_word;
      OFF_RESULT: read_word = result_q;
      OFF_STATUS: read_word = status_word;
      default: read_word = UNMAPPED_READ;
    endcase
  end

  // Operand registers, byte-lane writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      opnd_first_q <= ZERO_WORD;
      opnd_second_q <= ZERO_WORD;
      accum_q <= ZERO_WORD;
    end else if (clk_en) begin
      if (wr_first) begin
        opnd_first_q <= merge_bytes(opnd_first_q, wb_dat_i, wb_sel_i);
      end
      if (wr_second) begin
        opnd_second_q <= merge_bytes(opnd_second_q, wb_dat_i, wb_sel_i);
      end
      if (wr_accum) begin
        accum_q <= merge_bytes(accum_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Wide pair: preset by software, overwritten by wide forms
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wide_upper_q <= ZERO_WORD;
      wide_lower_q <= ZERO_WORD;
    end else if (clk_en) begin
      if (fire_q && opif.writes_wide) begin
        wide_upper_q <= opif.wide_upper_res;
        wide_lower_q <= opif.wide_lower_res;
      end else begin
        if (wr_upper) begin
          wide_upper_q <= merge_bytes(wide_upper_q, wb_dat_i, wb_sel_i);
        end
        if (wr_lower) begin
          wide_lower_q <= merge_bytes(wide_lower_q, wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // Single destination, read only to software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      result_q <= ZERO_WORD;
    end else if (clk_en && fire_q && opif.writes_single) begin
      result_q <= opif.result;
    end
  end

  // Operation select
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      op_q <= OP_PRODUCT_LOW;
      sel_first_top_q <= 1'b0;
      sel_second_top_q <= 1'b0;
      set_flags_q <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      op_q <= mac_op_t'(wb_dat_i[CTRL_OP_LSB +: CTRL_OP_W]);
      sel_first_top_q <= wb_dat_i[CTRL_SEL_FIRST_BIT];
      sel_second_top_q <= wb_dat_i[CTRL_SEL_SECOND_BIT];
      set_flags_q <= wb_dat_i[CTRL_SET_FLAGS_BIT];
    end
  end

  // Execute one cycle after the go write; the next access cannot collide
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fire_q <= 1'b0;
    end else if (clk_en) begin
      fire_q <= go;
    end
  end

  // Flags: only the flag logic and status writes move them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags_q <= mac_flags_t'(STAT_RESET);
    end else if (clk_en) begin
      flags_q <= opif.flags_next;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence seq_req_start;
    clk_en && req && !ack_q;
  endsequence
  sequence seq_go_taken;
    clk_en && go;
  endsequence
  sequence seq_fire(mac_op_t code);
    clk_en && fire_q && op_q == code;
  endsequence

  AST_BUS_ACK: assert property (seq_req_start |=> wb_ack_o ##1 (!wb_ack_o || !$past(clk_en)))
    else $error("ack not a single cycle after request");
  AST_GO_FIRE: assert property (seq_go_taken |=> fire_q ##1 (!fire_q || !$past(clk_en)))
    else $error("go write did not give one execute pulse");
  AST_PRODUCT_LOW: assert property (seq_fire(OP_PRODUCT_LOW) |=>
    result_q == DATA_W'(opnd_first_q * opnd_second_q))
    else $error("plain product low word wrong");
  AST_PLUS_ADDEND: assert property (seq_fire(OP_PRODUCT_PLUS_ADDEND) |=>
    result_q == DATA_W'(accum_q + opnd_first_q * opnd_second_q))
    else $error("product plus addend wrong");
  AST_MINUS_PRODUCT: assert property (seq_fire(OP_ADDEND_MINUS_PRODUCT) |=>
    result_q == DATA_W'(accum_q - opnd_first_q * opnd_second_q))
    else $error("addend minus product wrong");
  AST_SIGNED_SAME: assert property (seq_fire(OP_PRODUCT_LOW) |=>
    result_q == DATA_W'(signed'(opnd_first_q) * signed'(opnd_second_q)))
    else $error("signed low word differs");
  AST_NZ_UPDATE: assert property (seq_fire(OP_PRODUCT_LOW) ##0 (set_flags_q && !wr_stat) |=>
    flags_q.n == result_q[DATA_W-1] && flags_q.z == (result_q == ZERO_WORD)
    && flags_q.c == $past(flags_q.c) && flags_q.v == $past(flags_q.v))
    else $error("N Z update wrong");
  AST_WIDE_PRODUCT: assert property (seq_fire(OP_UNSIGNED_WIDE_PRODUCT) |=>
    {wide_upper_q, wide_lower_q} == WIDE_W'(opnd_first_q) * WIDE_W'(opnd_second_q))
    else $error("wide product wrong");
  AST_WIDE_DOUBLE: assert property (seq_fire(OP_WIDE_DOUBLE_ACCUM) |=>
    {wide_upper_q, wide_lower_q} == WIDE_W'(opnd_first_q) * WIDE_W'(opnd_second_q)
    + WIDE_W'($past(wide_upper_q)) + WIDE_W'($past(wide_lower_q)))
    else $error("double accumulate wrong");
  AST_WIDE_ACCUM: assert property (seq_fire(OP_WIDE_ACCUM) |=>
    {wide_upper_q, wide_lower_q} == WIDE_W'(opnd_first_q) * WIDE_W'(opnd_second_q)
    + {$past(wide_upper_q), $past(wide_lower_q)})
    else $error("wide accumulate wrong");
  AST_WIDE_FLAGS: assert property (clk_en && fire_q && opif.writes_wide && !wr_stat |=>
    flags_q == $past(flags_q))
    else $error("wide form moved flags");
  AST_HALF_HALF: assert property (seq_fire(OP_HALF_BY_HALF_ACCUM) |=>
    result_q == DATA_W'(accum_q + half_ext(opnd_first_q, sel_first_top_q)
    * half_ext(opnd_second_q, sel_second_top_q)))
    else $error("half by half accumulate wrong");
  AST_WORD_HALF: assert property (seq_fire(OP_WORD_BY_HALF_ACCUM) |=>
    result_q == DATA_W'(accum_q + DATA_W'((WH_W'(signed'(opnd_first_q))
    * half_ext(opnd_second_q, sel_second_top_q)) >>> HALF_W)))
    else $error("word by half accumulate wrong");
  AST_Q_SET: assert property (clk_en && fire_q && (op_q == OP_HALF_BY_HALF_ACCUM
    || op_q == OP_WORD_BY_HALF_ACCUM) && opif.acc_overflow |=> flags_q.q)
    else $error("saturation flag not set");
  AST_DUAL: assert property (seq_fire(OP_DUAL_HALF_ACCUM) |=>
    result_q == DATA_W'(accum_q + half_ext(opnd_first_q, 1'b1) * half_ext(opnd_second_q, 1'b1)
    + half_ext(opnd_first_q, 1'b0) * half_ext(opnd_second_q, 1'b0)))
    else $error("straight dual wrong");
  AST_DUAL_CROSSED: assert property (seq_fire(OP_DUAL_HALF_CROSSED_ACCUM) |=>
    result_q == DATA_W'(accum_q + half_ext(opnd_first_q, 1'b1) * half_ext(opnd_second_q, 1'b0)
    + half_ext(opnd_first_q, 1'b0) * half_ext(opnd_second_q, 1'b1)))
    else $error("crossed dual wrong");
  AST_DUAL_FLAGS: assert property (clk_en && fire_q && (op_q == OP_DUAL_HALF_ACCUM
    || op_q == OP_DUAL_HALF_CROSSED_ACCUM) && !wr_stat |=> $stable(flags_q))
    else $error("dual form moved flags");
  AST_Q_STICKY: assert property (flags_q.q && !(clk_en && wr_stat) |=> flags_q.q)
    else $error("saturation flag cleared without status write");
endmodule : mac_unit
`default_nettype wire

// ===== sim/mac_issuer_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_issuer_model (
  // Clock
  input wire logic core_clk,
  // Answer from the unit
  input wire logic wb_ack_o,
  input wire logic [mac_pkg::DATA_W-1:0] wb_dat_o,
  // Request to the unit
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [mac_pkg::ADR_W-1:0] wb_adr_i,
  output logic [mac_pkg::DATA_W-1:0] wb_dat_i,
  output logic [mac_pkg::SEL_W-1:0] wb_sel_i
);
  import mac_pkg::*;
  // Idle bus at time zero
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hf;
  end
  // Each operand lives in its own register, so sources and the wide pair never alias
  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic xfer(input logic w, input logic [ADR_W-1:0] ad, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] r);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    // No timeout here: this wait ends on ack, or at the bench's hang guard
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    // Released data is inverted so a stale value can never look valid
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask : xfer
endmodule : mac_issuer_model
`default_nettype wire

// ===== sim/multiply_accumulate_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module multiply_accumulate_unit_tb;
  import mac_pkg::*;
  // Clock, reset and bus
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
  logic [SEL_W-1:0] wb_sel_i;
  // Operand set and expected flags
  logic [31:0] a, b, c, hi, lo, r;
  logic [4:0] st;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  mac_unit #(.WORD_W(32)) dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  mac_issuer_model issuer_u (.core_clk(core_clk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i));
  // Reference arithmetic, written independently of the design
  function automatic logic [63:0] model(input logic [3:0] op, input logic s1, input logic s2);
    logic signed [31:0] at, ab, bt, bb, h1, h2;
    logic signed [47:0] w;
    logic [63:0] u;
    at = $signed(a[31:16]);
    ab = $signed(a[15:0]);
    bt = $signed(b[31:16]);
    bb = $signed(b[15:0]);
    h1 = s1 ? at : ab;
    h2 = s2 ? bt : bb;
    u = {32'h0000_0000, a} * {32'h0000_0000, b};
    w = $signed(a) * h2;
    case (op)
      4'd0: model = {32'h0000_0000, a * b};
      4'd1: model = {32'h0000_0000, a * b + c};
      4'd2: model = {32'h0000_0000, c - a * b};
      4'd3: model = u;
      4'd4: model = u + {32'h0000_0000, hi} + {32'h0000_0000, lo};
      4'd5: model = u + {hi, lo};
      4'd6: model = {32'h0000_0000, h1 * h2 + c};
      4'd7: model = {32'h0000_0000, w[47:16] + c};
      4'd8: model = {32'h0000_0000, at * bt + ab * bb + c};
      default: model = {32'h0000_0000, at * bb + ab * bt + c};
    endcase
  endfunction : model
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Load all sources, fire one operation, then check result (wide pair for wide forms) and flags
  task automatic run(input logic [3:0] op, input logic s1, input logic s2, input logic sf);
    logic [31:0] r1, r2;
    issuer_u.xfer(1'b1, OFF_OPND_FIRST, a, r1);
    issuer_u.xfer(1'b1, OFF_OPND_SECOND, b, r1);
    issuer_u.xfer(1'b1, OFF_ACCUM, c, r1);
    issuer_u.xfer(1'b1, OFF_WIDE_UPPER, hi, r1);
    issuer_u.xfer(1'b1, OFF_WIDE_LOWER, lo, r1);
    issuer_u.xfer(1'b1, OFF_CTRL, {24'h00_0000, 1'b1, sf, s2, s1, op}, r1);
    if (op inside {4'd3, 4'd4, 4'd5}) begin
      issuer_u.xfer(1'b0, OFF_WIDE_UPPER, ZERO_WORD, r1);
      issuer_u.xfer(1'b0, OFF_WIDE_LOWER, ZERO_WORD, r2);
      chk("wide pair", model(op, s1, s2), {r1, r2});
    end else begin
      issuer_u.xfer(1'b0, OFF_RESULT, ZERO_WORD, r1);
      chk("result", model(op, s1, s2), {32'h0000_0000, r1});
    end
    issuer_u.xfer(1'b0, OFF_STATUS, ZERO_WORD, r1);
    chk("status", {59'h0, st}, {58'h0, r1[5:0]});
  endtask : run
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    issuer_u.xfer(1'b0, OFF_STATUS, ZERO_WORD, r);
    chk("status after reset", 64'h0, {32'h0000_0000, r});
    // Preset C and V so untouched flags are visible
    issuer_u.xfer(1'b1, OFF_STATUS, 32'h0000_0006, r);
    a = 32'hffff_8003;
    b = 32'h7ffe_0005;
    c = 32'h0000_1234;
    hi = 32'hf000_0001;
    lo = 32'hffff_fff0;
    st = 5'h06;
    // Every code with every halfword selection
    for (int op = 0; op < 10; op++) begin
      for (int k = 0; k < 4; k++) begin
        run(op[3:0], k[0], k[1], 1'b0);
      end
    end
    a = 32'h0000_0000;
    st = 5'h0e;
    run(4'd0, 1'b0, 1'b0, 1'b1);
    a = 32'h0000_0001;
    b = 32'h0000_0001;
    c = 32'h7fff_ffff;
    st = 5'h0f;
    run(4'd6, 1'b0, 1'b0, 1'b0);
    // Clear saturation so the word-by-half form must set it again
    issuer_u.xfer(1'b1, OFF_STATUS, 32'h0000_000e, r);
    a = 32'h0001_0000;
    run(4'd7, 1'b0, 1'b0, 1'b0);
    a = 32'hffff_ffff;
    st = 5'h17;
    run(4'd0, 1'b0, 1'b0, 1'b1);
    // Undefined code with go: result and flags stay put
    issuer_u.xfer(1'b1, OFF_CTRL, 32'h0000_008a, r);
    issuer_u.xfer(1'b0, OFF_RESULT, ZERO_WORD, r);
    chk("refused code result", 64'h0000_0000_ffff_ffff, {32'h0000_0000, r});
    issuer_u.xfer(1'b0, OFF_STATUS, ZERO_WORD, r);
    chk("refused code status", {59'h0, st}, {58'h0, r[5:0]});
    issuer_u.xfer(1'b1, OFF_STATUS, ZERO_WORD, r);
    issuer_u.xfer(1'b0, OFF_STATUS, ZERO_WORD, r);
    chk("status cleared", 64'h0, {58'h0, r[5:0]});
    // Unmapped place and read-only result
    issuer_u.xfer(1'b1, 8'hfc, 32'h1234_5678, r);
    issuer_u.xfer(1'b0, 8'hfc, ZERO_WORD, r);
    chk("unmapped", 64'h0, {32'h0000_0000, r});
    issuer_u.xfer(1'b1, OFF_RESULT, 32'h0000_0000, r);
    issuer_u.xfer(1'b0, OFF_RESULT, ZERO_WORD, r);
    chk("result kept", 64'h0000_0000_ffff_ffff, {32'h0000_0000, r});
    // Freeze for three edges during a read; the answer waits for the enable
    @(posedge core_clk);
    clk_en <= 1'b0;
    fork
      issuer_u.xfer(1'b0, OFF_RESULT, ZERO_WORD, r);
      begin
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
      end
    join
    chk("result after freeze", 64'h0000_0000_ffff_ffff, {32'h0000_0000, r});
    conclude();
  end
endmodule : multiply_accumulate_unit_tb
`default_nettype wire
